// [sfc_pkg.sv]
/*
 * sfc_pkg: constants, opcodes and types of the serial flash command front end.
 * Assumes: one 100 MHz clock; pin levels arrive already synchronous to it.
 */
// Functional notes
// - write-protect low shields flagged sectors from writes
// - pin and software protection act independently
// - write-protect low freezes the sector protection flags
// - program/erase under write-protect dropped, idle after deselect
// - enable-protection and lockdown still work under write-protect
// - reset pin low aborts work, forces idle
// - held in reset while reset pin low
// - internal power-on reset, no reset pin demands
// - program per page; erase page/block/sector/chip
// - chip-select fall, 8-bit opcode, then address
// - everything shifted most significant bit first
// - 528 mode: 12-bit page, 10-bit byte
// - 512 mode: 21-bit linear, 12 page, 9 byte
// - array read; clock modes 0 and 3
// - legacy read: opcode, 3 address, 4 dummy bytes
// - read address counter advances by itself
// - page end continues at next page, no gap
// - array end wraps to first page, no gap
// - chip-select rise ends read, output released
// - continuous read leaves the buffers untouched
// - sample input on rising, launch on falling edge
// - deselected: input ignored, output off; busy blocks standby
package sfc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned   CLK_HZ      = 100_000_000;
   localparam int unsigned   POR_TIME_NS = 1000;
   localparam int unsigned   POR_CYCLES  = (POR_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam logic [7:0]    POR_COUNT   = 8'(POR_CYCLES);

   // ----------------------------------------------------------------
   // framing and address layout
   // ----------------------------------------------------------------
   localparam logic [2:0]    BIT_LAST    = 3'h7;
   localparam logic [2:0]    ADDR_BYTES  = 3'h3;
   localparam logic [2:0]    ADDR_LAST   = ADDR_BYTES - 3'h1;
   localparam logic [2:0]    DUMMY_BYTES = 3'h4;
   localparam logic [2:0]    DUMMY_LAST  = DUMMY_BYTES - 3'h1;
   localparam int unsigned   PAGE_W      = 12;
   localparam int unsigned   BYTE_W      = 10;
   localparam logic [9:0]    LAST_528    = 10'h20f;
   localparam logic [9:0]    LAST_512    = 10'h1ff;
   localparam int unsigned   SECTORS     = 16;
   localparam int unsigned   SECT_W      = 4;
   localparam logic [4:0]    SECT_COUNT  = 5'h10;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0]    OPC_READ       = 8'he8;
   localparam logic [7:0]    OPC_PROG       = 8'h10;
   localparam logic [7:0]    OPC_ERASE_PAGE = 8'h20;
   localparam logic [7:0]    OPC_ERASE_BLK  = 8'h21;
   localparam logic [7:0]    OPC_ERASE_SECT = 8'h22;
   localparam logic [7:0]    OPC_ERASE_CHIP = 8'h23;
   localparam logic [7:0]    OPC_PROT_EN    = 8'h30;
   localparam logic [7:0]    OPC_PROT_DIS   = 8'h31;
   localparam logic [7:0]    OPC_PROT_WRITE = 8'h32;
   localparam logic [7:0]    OPC_LOCK       = 8'h33;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_WDATA, ST_WAIT} sfc_state_e;
   typedef enum logic [2:0] {OP_PROG, OP_ERASE_PAGE, OP_ERASE_BLK, OP_ERASE_SECT, OP_ERASE_CHIP} sfc_op_e;

endpackage : sfc_pkg

// [sfc_addr_if.sv]
/*
 * sfc_addr_if: link between the command front end and the read address counter.
 * Assumes: both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface sfc_addr_if;
   logic         load;      // take start address
   logic         step;      // advance one byte
   logic         mode512;   // binary page size
   logic [11:0]  loadPage;  // start page
   logic [9:0]   loadByte;  // start byte
   logic [11:0]  page;      // current page
   logic [9:0]   byteOfs;   // current byte

   modport ctl (output load, step, mode512, loadPage, loadByte, input page, byteOfs);
   modport cnt (input load, step, mode512, loadPage, loadByte, output page, byteOfs);
endinterface : sfc_addr_if
`default_nettype wire

// [sfc_addr_counter.sv]
/*
 * sfc_addr_counter: page and byte counter of the continuous array read.
 * Assumes: load and step never come together; step only while reading.
 */
`timescale 1ns/1ps
`default_nettype none
module sfc_addr_counter (
   input  wire logic  clock,   // 100 MHz clock
   input  wire logic  arst_n,  // async reset, low
   sfc_addr_if.cnt    acc      // counter side
);

   logic [11:0]  page_reg;
   logic [9:0]   byte_reg;
   logic [9:0]   lastByte;

   // last byte of a page in the current page size
   assign lastByte = acc.mode512 ? sfc_pkg::LAST_512 : sfc_pkg::LAST_528;

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   // load, then step; page crossing and array wrap cost no extra cycle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         page_reg <= 12'h000;
         byte_reg <= 10'h000;
      end else if (acc.load) begin
         page_reg <= acc.loadPage;
         byte_reg <= acc.loadByte;
      end else if (acc.step) begin
         if (byte_reg == lastByte) begin
            byte_reg <= 10'h000;
            page_reg <= page_reg + 12'h001;
         end else begin
            byte_reg <= byte_reg + 10'h001;
         end
      end
   end

   assign acc.page    = page_reg;
   assign acc.byteOfs = byte_reg;

endmodule : sfc_addr_counter
`default_nettype wire

// [sfc_front_end.sv]
/*
 * sfc_front_end: serial command front end of a flash memory: framing,
 * legacy continuous array read, write-protect gating, protection flags,
 * reset pin and power-on reset.
 * Assumes: csN, sck, si, wpN and resetN are sampled at the 100 MHz clock and
 * sck is slow enough that each of its edges spans at least one clock; the
 * array core answers arrayData combinationally for arrayPage/arrayByte and
 * reports coreBusy while a self-timed program or erase runs.
 */
`timescale 1ns/1ps
`default_nettype none
module sfc_front_end (
   input  wire logic          clock,        // 100 MHz clock
   input  wire logic          arst_n,       // async reset, low
   input  wire logic          csN,          // chip select, low
   input  wire logic          sck,          // serial clock level
   input  wire logic          si,           // serial data in
   output var  logic          so,           // serial data out
   output var  logic          soOe,         // so drive enable
   input  wire logic          wpN,          // write protect, low
   input  wire logic          resetN,       // reset pin, low
   input  wire logic          pageMode512,  // binary page size
   input  wire logic [7:0]    arrayData,    // byte at array address
   output logic [11:0]        arrayPage,    // array read page
   output logic [9:0]         arrayByte,    // array read byte
   output logic               arrayFetch,   // byte taken, pulse
   output var  logic [7:0]    wrData,       // program data byte
   output var  logic          wrStrobe,     // program data valid
   output var  logic          opStart,      // start core op, pulse
   output var  logic [2:0]    opKind,       // core op kind
   output var  logic [11:0]   opPage,       // core op page
   input  wire logic          coreBusy,     // core op running
   output logic               coreAbort,    // abort core op
   output logic               standby,      // idle and deselected
   output logic               protEnabled   // software protection on
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   sfc_pkg::sfc_state_e                 state_reg;
   logic [7:0]                          opcode_reg;
   logic [23:0]                         addr_reg;
   logic [23:0]                         addrNext;
   logic [2:0]                          byteCnt_reg;
   logic                                complete_reg;
   logic [7:0]                          inShift_reg;
   logic [2:0]                          bitCnt_reg;
   logic [7:0]                          outShift_reg;
   logic [2:0]                          outCnt_reg;
   logic                                sckPrev_reg;
   logic                                csPrev_reg;
   logic [7:0]                          porCnt_reg;
   logic [sfc_pkg::SECTORS-1:0]         protFlag_reg;
   logic [sfc_pkg::SECTORS-1:0]         lockFlag_reg;
   logic                                swEn_reg;
   logic [4:0]                          protIdx_reg;
   logic                                hold;
   logic                                sckRise;
   logic                                sckFall;
   logic                                csRise;
   logic                                csFall;
   logic                                byteDone;
   logic [7:0]                          newByte;
   logic                                wpLow;
   logic [11:0]                         cmdPage;
   logic                                refused;
   logic                                isCore;
   sfc_pkg::sfc_op_e                    kind;

   sfc_addr_if acc ();

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // page field of a received address in either page size
   function automatic logic [11:0] pageOf(input logic [23:0] a, input logic m512);
      pageOf = m512 ? a[20:9] : a[21:10];
   endfunction : pageOf

   // byte field of a received address in either page size
   function automatic logic [9:0] byteOf(input logic [23:0] a, input logic m512);
      byteOf = m512 ? {1'b0, a[8:0]} : a[9:0];
   endfunction : byteOf

   // opcodes that carry three address bytes
   function automatic logic needsAddr(input logic [7:0] op);
      needsAddr = (op == sfc_pkg::OPC_READ) || (op == sfc_pkg::OPC_PROG)
               || (op == sfc_pkg::OPC_ERASE_PAGE) || (op == sfc_pkg::OPC_ERASE_BLK)
               || (op == sfc_pkg::OPC_ERASE_SECT) || (op == sfc_pkg::OPC_LOCK);
   endfunction : needsAddr

   // opcodes complete with the opcode byte alone
   function automatic logic bareCmd(input logic [7:0] op);
      bareCmd = (op == sfc_pkg::OPC_ERASE_CHIP) || (op == sfc_pkg::OPC_PROT_EN)
             || (op == sfc_pkg::OPC_PROT_DIS);
   endfunction : bareCmd

   // sector shielded by the pin term or the software term, or locked
   function automatic logic secBlocked(input logic [sfc_pkg::SECTORS-1:0] prot,
                                       input logic [sfc_pkg::SECTORS-1:0] lock,
                                       input logic sw, input logic wpl,
                                       input logic [sfc_pkg::SECT_W-1:0] s);
      secBlocked = (wpl && prot[s]) || (sw && prot[s]) || lock[s];
   endfunction : secBlocked

   // ----------------------------------------------------------------
   // reset: power-on counter and reset pin
   // ----------------------------------------------------------------
   // internal power-on reset holds the block after arst_n release
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         porCnt_reg <= 8'h00;
      end else if (porCnt_reg != sfc_pkg::POR_COUNT) begin
         porCnt_reg <= porCnt_reg + 8'h01;
      end
   end

   // held idle while power-on runs or the reset pin is low
   assign hold      = (porCnt_reg != sfc_pkg::POR_COUNT) || !resetN;
   assign coreAbort = hold;

   // ----------------------------------------------------------------
   // pin edges
   // ----------------------------------------------------------------
   // previous levels of sck and chip select
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sckPrev_reg <= 1'b0;
         csPrev_reg  <= 1'b1;
      end else begin
         sckPrev_reg <= sck;
         csPrev_reg  <= csN;
      end
   end

   assign sckRise = sck && !sckPrev_reg;
   assign sckFall = !sck && sckPrev_reg;
   assign csFall  = !csN && csPrev_reg;
   assign csRise  = csN && !csPrev_reg;
   assign wpLow   = !wpN;

   // ----------------------------------------------------------------
   // input shifter
   // ----------------------------------------------------------------
   // msb first, sampled on rising sck, only while selected
   assign newByte  = {inShift_reg[6:0], si};
   assign byteDone = sckRise && !csN && !hold && (bitCnt_reg == sfc_pkg::BIT_LAST);
   assign addrNext = {addr_reg[15:0], newByte};

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         inShift_reg <= 8'h00;
         bitCnt_reg  <= 3'h0;
      end else if (hold || csN) begin
         bitCnt_reg  <= 3'h0;
      end else if (sckRise) begin
         inShift_reg <= newByte;
         bitCnt_reg  <= bitCnt_reg + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   // opcode, address and dummy framing; deselect always returns to idle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg    <= sfc_pkg::ST_IDLE;
         opcode_reg   <= 8'h00;
         addr_reg     <= 24'h000000;
         byteCnt_reg  <= 3'h0;
         complete_reg <= 1'b0;
      end else if (hold) begin
         state_reg    <= sfc_pkg::ST_IDLE;
         complete_reg <= 1'b0;
      end else if (csN) begin
         state_reg    <= sfc_pkg::ST_IDLE;
         complete_reg <= 1'b0;
      end else if (csFall) begin
         state_reg    <= sfc_pkg::ST_OPCODE;
         byteCnt_reg  <= 3'h0;
         complete_reg <= 1'b0;
      end else if (byteDone) begin
         case (state_reg)
            sfc_pkg::ST_OPCODE: begin
               opcode_reg  <= newByte;
               byteCnt_reg <= 3'h0;
               if (needsAddr(newByte)) begin
                  state_reg <= sfc_pkg::ST_ADDR;
               end else if (newByte == sfc_pkg::OPC_PROT_WRITE) begin
                  state_reg    <= sfc_pkg::ST_WDATA;
                  complete_reg <= 1'b1;
               end else begin
                  state_reg    <= sfc_pkg::ST_WAIT;
                  complete_reg <= bareCmd(newByte);
               end
            end
            sfc_pkg::ST_ADDR: begin
               addr_reg    <= addrNext;
               byteCnt_reg <= byteCnt_reg + 3'h1;
               if (byteCnt_reg == sfc_pkg::ADDR_LAST) begin
                  byteCnt_reg  <= 3'h0;
                  complete_reg <= 1'b1;
                  if (opcode_reg == sfc_pkg::OPC_READ) begin
                     state_reg <= sfc_pkg::ST_DUMMY;
                  end else if (opcode_reg == sfc_pkg::OPC_PROG) begin
                     state_reg <= sfc_pkg::ST_WDATA;
                  end else begin
                     state_reg <= sfc_pkg::ST_WAIT;
                  end
               end
            end
            sfc_pkg::ST_DUMMY: begin
               byteCnt_reg <= byteCnt_reg + 3'h1;
               if (byteCnt_reg == sfc_pkg::DUMMY_LAST) begin
                  state_reg <= sfc_pkg::ST_READ;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // array read path
   // ----------------------------------------------------------------
   // counter loads at the last address byte; steps as each byte is taken
   assign acc.mode512  = pageMode512;
   assign acc.load     = byteDone && (state_reg == sfc_pkg::ST_ADDR)
                      && (byteCnt_reg == sfc_pkg::ADDR_LAST) && (opcode_reg == sfc_pkg::OPC_READ);
   assign acc.loadPage = pageOf(addrNext, pageMode512);
   assign acc.loadByte = byteOf(addrNext, pageMode512);
   assign acc.step     = sckFall && !csN && !hold && (state_reg == sfc_pkg::ST_READ)
                      && (outCnt_reg == 3'h0);
   assign arrayPage    = acc.page;
   assign arrayByte    = acc.byteOfs;
   assign arrayFetch   = acc.step;

   sfc_addr_counter u_counter (
      .clock  (clock),
      .arst_n (arst_n),
      .acc    (acc.cnt)
   );

   // output shifter: launch on falling sck, msb first, released on deselect
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         outShift_reg <= 8'h00;
         outCnt_reg   <= 3'h0;
         so           <= 1'b0;
         soOe         <= 1'b0;
      end else if (hold || csN) begin
         outCnt_reg   <= 3'h0;
         so           <= 1'b0;
         soOe         <= 1'b0;
      end else if ((state_reg == sfc_pkg::ST_READ) && sckFall) begin
         soOe         <= 1'b1;
         outCnt_reg   <= outCnt_reg + 3'h1;
         if (outCnt_reg == 3'h0) begin
            so           <= arrayData[7];
            outShift_reg <= {arrayData[6:0], 1'b0};
         end else begin
            so           <= outShift_reg[7];
            outShift_reg <= {outShift_reg[6:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // protection state
   // ----------------------------------------------------------------
   // flag writes refused under write-protect; enable and lockdown still act
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         protFlag_reg <= '0;
         lockFlag_reg <= '0;
         swEn_reg     <= 1'b0;
         protIdx_reg  <= 5'h00;
      end else if (!hold) begin
         if (csFall) begin
            protIdx_reg <= 5'h00;
         end else if (byteDone && (state_reg == sfc_pkg::ST_WDATA)
                      && (opcode_reg == sfc_pkg::OPC_PROT_WRITE)
                      && (protIdx_reg < sfc_pkg::SECT_COUNT)) begin
            protIdx_reg <= protIdx_reg + 5'h01;
            if (!wpLow) begin
               protFlag_reg[protIdx_reg[3:0]] <= (newByte != 8'h00);
            end
         end
         if (csRise && complete_reg) begin
            if (opcode_reg == sfc_pkg::OPC_PROT_EN) begin
               swEn_reg <= 1'b1;
            end else if (opcode_reg == sfc_pkg::OPC_PROT_DIS) begin
               swEn_reg <= 1'b0;
            end else if (opcode_reg == sfc_pkg::OPC_LOCK) begin
               lockFlag_reg[cmdPage[11:8]] <= 1'b1;
            end
         end
      end
   end

   assign protEnabled = swEn_reg;

   // ----------------------------------------------------------------
   // program and erase gating
   // ----------------------------------------------------------------
   // kind of core operation and whether it is refused
   assign cmdPage = pageOf(addr_reg, pageMode512);

   always_comb begin
      isCore = 1'b1;
      kind   = sfc_pkg::OP_PROG;
      if (opcode_reg == sfc_pkg::OPC_PROG) begin
         kind = sfc_pkg::OP_PROG;
      end else if (opcode_reg == sfc_pkg::OPC_ERASE_PAGE) begin
         kind = sfc_pkg::OP_ERASE_PAGE;
      end else if (opcode_reg == sfc_pkg::OPC_ERASE_BLK) begin
         kind = sfc_pkg::OP_ERASE_BLK;
      end else if (opcode_reg == sfc_pkg::OPC_ERASE_SECT) begin
         kind = sfc_pkg::OP_ERASE_SECT;
      end else if (opcode_reg == sfc_pkg::OPC_ERASE_CHIP) begin
         kind = sfc_pkg::OP_ERASE_CHIP;
      end else begin
         isCore = 1'b0;
      end
   end

   // pin protection drops the command outright; sectors checked otherwise
   always_comb begin
      refused = wpLow || coreBusy;
      if (kind == sfc_pkg::OP_ERASE_CHIP) begin
         refused = refused || (|lockFlag_reg) || (swEn_reg && (|protFlag_reg));
      end else begin
         refused = refused || secBlocked(protFlag_reg, lockFlag_reg, swEn_reg, wpLow, cmdPage[11:8]);
      end
   end

   // program data bytes pass only for an accepted program
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrData   <= 8'h00;
         wrStrobe <= 1'b0;
      end else begin
         wrStrobe <= byteDone && (state_reg == sfc_pkg::ST_WDATA)
                  && (opcode_reg == sfc_pkg::OPC_PROG) && !refused;
         if (byteDone) begin
            wrData <= newByte;
         end
      end
   end

   // core operation starts at deselect of a complete, accepted command
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         opStart <= 1'b0;
         opKind  <= 3'h0;
         opPage  <= 12'h000;
      end else begin
         opStart <= !hold && csRise && complete_reg && isCore && !refused;
         if (csRise && complete_reg && isCore) begin
            opKind <= kind;
            opPage <= cmdPage;
         end
      end
   end

   // standby only once deselected and the core is done
   assign standby = csN && !coreBusy;

endmodule : sfc_front_end
`default_nettype wire

// [sfc_core_model.sv]
/* sfc_core_model: array core stand-in behind the front end.
   Assumes the front end drives address and op start from one clock. */
`timescale 1ns/1ps
`default_nettype none
module sfc_core_model (
   input  wire logic        clock,      // clock
   input  wire logic        opStart,    // op start pulse
   input  wire logic [11:0] arrayPage,  // read page
   input  wire logic [9:0]  arrayByte,  // read byte
   output logic [7:0]       arrayData,  // byte at address
   output logic             coreBusy    // self-timed op runs
);
   int left = 0;
   // content follows the address; busy 20 clocks per op
   assign arrayData = {arrayPage[1:0], 6'h0} ^ arrayByte[7:0];
   always @(posedge clock) left <= (opStart === 1'b1) ? 20 : (left > 0 ? left - 1 : 0);
   assign coreBusy = (left > 0);
endmodule : sfc_core_model
`default_nettype wire

// [sfc_fe_asserts.sv]
/* sfc_fe_asserts: pin-level checks of sfc_front_end.
   Assumes it is bound to the front end ports. */
`timescale 1ns/1ps
`default_nettype none
module sfc_fe_asserts (
   input wire logic clock, arst_n, csN, sck, wpN, resetN, coreBusy,  // pins in
   input wire logic soOe, opStart, coreAbort, standby, arrayFetch    // design out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic [7:0] up_reg;
   // clocks since reset release, saturating
   always_ff @(posedge clock or negedge arst_n)
      if (!arst_n) up_reg <= 8'h0;
      else if (up_reg != 8'hff) up_reg <= up_reg + 8'h1;
   sequence s_desel; csN [*3]; endsequence
   sequence s_pinrst; !resetN [*3]; endsequence
   a_por_hold: assert property (up_reg < 8'h64 |-> coreAbort) else $error("hold ended early");
   a_pin_hold: assert property (s_pinrst |-> coreAbort) else $error("reset pin not held");
   a_hold_quiet: assert property (coreAbort [*2] |-> !opStart && !arrayFetch && !soOe) else $error("busy in hold");
   a_desel_off: assert property (s_desel |-> !soOe) else $error("so driven deselected");
   a_wp_blocks: assert property (!wpN [*3] |-> !opStart) else $error("op under write protect");
   a_start_desel: assert property (opStart |-> csN && $past(csN)) else $error("op start while selected");
   a_busy_blocks: assert property (coreBusy [*2] |-> !opStart) else $error("op start while busy");
   a_fetch_sel: assert property (arrayFetch |-> !$past(csN)) else $error("fetch deselected");
   a_launch_fall: assert property ($rose(soOe) |-> !sck && !$past(sck)) else $error("launch not on fall");
   a_standby_def: assert property (standby == (csN && !coreBusy)) else $error("standby wrong");
endmodule : sfc_fe_asserts
bind sfc_front_end sfc_fe_asserts u_chk (.clock, .arst_n, .csN, .sck, .wpN, .resetN, .coreBusy, .soOe,
   .opStart, .coreAbort, .standby, .arrayFetch);
`default_nettype wire

// [sfc_front_end_tb.sv]
/* sfc_front_end_tb: scenario bench of the front end.
   Assumes sfc_core_model as array core and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module sfc_front_end_tb;
   logic clock = 1'b0, arst_n = 1'b0, csN = 1'b1, sck = 1'b0, si = 1'b0, wpN = 1'b1, resetN = 1'b1;
   logic pageMode512 = 1'b0, so, soOe, coreBusy, coreAbort, opStart, wrStrobe, protEnabled;
   logic [7:0] arrayData, rx, wrData;
   logic [11:0] arrayPage, opPage;
   logic [9:0] arrayByte;
   logic [2:0] opKind;
   int n_fail = 0, checks_done = 0, starts = 0, strobes = 0;
   always #5 clock = ~clock;
   always @(posedge clock) if (opStart === 1'b1) starts++;  // op start count
   always @(posedge clock) if (wrStrobe === 1'b1) strobes++;
   sfc_front_end u_dut (.clock, .arst_n, .csN, .sck, .si, .so, .soOe, .wpN, .resetN, .pageMode512,
      .arrayData, .arrayPage, .arrayByte, .arrayFetch(), .wrData, .wrStrobe, .opStart, .opKind,
      .opPage, .coreBusy, .coreAbort, .standby(), .protEnabled);
   sfc_core_model u_core (.clock, .opStart, .arrayPage, .arrayByte, .arrayData, .coreBusy);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tk
   // one byte: fall, setup, rise; reply bit caught before the next fall
   task automatic xb(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si = tx[i];
         tk(3);
         sck = 1'b1;
         tk(3);
         rx[i] = so;
      end
   endtask : xb
   task automatic fr(input logic [7:0] op, input logic [23:0] a, input int n);
      csN = 1'b0;
      tk(3);
      xb(op);
      for (int i = n - 1; i >= 0; i--) xb(a[8*i+:8]);
   endtask : fr
   task automatic fe(input logic idle);
      tk(3);
      csN = 1'b1;
      tk(4);
      sck = idle;
   endtask : fe
   task automatic rd(input logic [11:0] p, input logic [9:0] b, input int n);
      repeat (4) xb(8'h00);
      repeat (n) begin
         xb(8'h00);
         check(rx, {p[1:0], 6'h0} ^ b[7:0]);
         check(soOe, 1'b1);
         b = b + 10'h1;
         if (b > (pageMode512 ? 10'h1ff : 10'h20f)) {p, b} = {p + 12'h1, 10'h0};
      end
   endtask : rd
   task automatic hold_wait;
      for (int i = 0; i < 300 && coreAbort !== 1'b0; i++) tk(1);
      check(coreAbort, 1'b0);
   endtask : hold_wait
   task automatic t_read;
      fr(8'he8, 24'h00060e, 3);
      rd(12'h001, 10'h20e, 3);
      fe(1'b1);
      check(soOe, 1'b0);
      pageMode512 = 1'b1;
      fr(8'he8, 24'h1fffff, 3);
      rd(12'hfff, 10'h1ff, 2);
      fe(1'b0);
      check(soOe, 1'b0);
      $display("read tests done");
   endtask : t_read
   task automatic t_ops;
      int s;
      for (int k = 0; k < 6; k++) begin
         wpN = (k != 0);
         s = starts;
         fr(k < 2 ? 8'h10 : 8'h1e + 8'(k), 24'h000400, 3);
         if (k < 2) xb(8'h5a);
         fe(1'b0);
         tk(30);
         check(starts - s, k != 0);
         if (k != 0) check(opKind, k - 1);
         if (k < 2) check(wrData, 8'h5a);
         if (k == 1) check(opPage, 12'h002);
      end
      check(strobes, 1);
      $display("op tests done");
   endtask : t_ops
   task automatic t_reset;
      fr(8'he8, 24'h000000, 3);
      rd(12'h000, 10'h000, 1);
      resetN = 1'b0;
      tk(4);
      check(coreAbort, 1'b1);
      check(soOe, 1'b0);
      fe(1'b0);
      check(coreAbort, 1'b1);
      resetN = 1'b1;
      hold_wait;
      $display("reset test done");
   endtask : t_reset
   task automatic t_prot;
      int s;
      fr(8'h32, 24'h1, 1);
      fe(1'b0);
      wpN = 1'b0;
      fr(8'h32, 24'h0, 1);
      fe(1'b0);
      fr(8'h30, 24'h0, 0);
      fe(1'b0);
      check(protEnabled, 1'b1);
      wpN = 1'b1;
      s = starts + strobes;
      fr(8'h10, 24'h000400, 3);
      xb(8'h5a);
      fe(1'b0);
      check(starts + strobes - s, 0);
      fr(8'h31, 24'h0, 0);
      fe(1'b0);
      check(protEnabled, 1'b0);
      $display("prot tests done");
   endtask : t_prot
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // main sequence, then a watchdog
   initial begin
      tk(2);
      arst_n = 1'b1;
      hold_wait;
      t_read;
      t_ops;
      t_prot;
      t_reset;
      summarize;
   end
   initial begin
      #150000;
      n_fail++;
      summarize;
   end
endmodule : sfc_front_end_tb
`default_nettype wire
